// [design/dws_supervisor.sv]
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dws_supervisor #(
    parameter logic [39:0] SHORT_WD_CYC   = dws_pkg::SHORT_WD_A_CYC,
    parameter logic        LONG_WD_EN     = 1'b1,
    parameter logic [39:0] LONG_WD_CYC    = dws_pkg::LONG_WD_A_CYC,
    parameter logic [39:0] RST_HOLD_CYC   = dws_pkg::RST_HOLD_A_CYC,
    parameter logic [39:0] CYC_HOLD_CYC   = dws_pkg::CYC_HOLD_CYC,
    parameter logic [39:0] POFF_CYC       = dws_pkg::POFF_A_CYC,
    parameter logic [39:0] SEQ_CYC        = dws_pkg::SEQ_DELAY_CYC,
    parameter logic [39:0] STATUS_CLR_CYC = dws_pkg::STATUS_CLR_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        short_refresh_in,
    input  wire logic        short_refresh_hiz_in,
    input  wire logic        long_refresh_in,
    input  wire logic        wd_lock_select,
    input  wire logic        manual_reset_n_in,
    input  wire logic        vout_low_in,
    input  wire logic        vcc_low_in,
    input  wire logic        buck_enable_in,
    input  wire logic        ldo_enable_in,
    input  wire logic        buck_mode_in,
    output logic             cpu_reset_n_out,
    output logic             cpu_reset_n_oe,
    output logic             timeout_status_out,
    output logic             timeout_status_oe,
    output logic             buck_on_out,
    output logic             ldo_on_out,
    output logic             buck_fpwm_out
);

    // ==========================================================
    // Helpers
    // Saturating persistence counter: counts while the level holds
    function automatic logic [39:0] sat_inc(input logic [39:0] cnt,
                                            input logic [39:0] lim,
                                            input logic        act);
        if (!act) begin
            sat_inc = 40'h0000000000;
        end else if (cnt == lim) begin
            sat_inc = cnt;
        end else begin
            sat_inc = cnt + 40'h0000000001;
        end
    endfunction

    // Last cycle of a period of lim cycles
    function automatic logic last(input logic [39:0] cnt, input logic [39:0] lim);
        last = (cnt == lim - 40'h0000000001);
    endfunction

    // ==========================================================
    // State
    logic [39:0]            mr_cnt_q;
    logic [39:0]            vout_cnt_q;
    logic [39:0]            vcc_cnt_q;
    logic [39:0]            short_cnt_q;
    logic [39:0]            long_cnt_q;
    logic [39:0]            hold_q;
    logic [39:0]            pc_cnt_q;
    logic [39:0]            stat_cnt_q;
    logic                   short_prev_q;
    logic                   long_prev_q;
    logic                   stat_low_q;
    logic                   sw_req_q;
    logic                   rst_q;
    dws_pkg::dws_pc_state_t state_q;
    dws_pkg::dws_cause_t    cause_q;
    logic [31:0]            prdata_q;
    logic                   pready_q;
    logic                   pslverr_q;
    logic                   buck_q;
    logic                   ldo_q;
    logic                   fpwm_q;

    logic                   mr_act;
    logic                   vout_act;
    logic                   vcc_act;
    logic                   short_kick;
    logic                   long_kick;
    logic                   short_en;
    logic                   short_exp;
    logic                   long_exp;
    logic                   access;
    logic                   wr_ctrl;
    logic                   wr_cause;
    logic [39:0]            pc_lim;
    dws_pkg::dws_cause_t    cause_set;

    // ==========================================================
    // Input qualification
    // Any transition on a refresh pin counts as a strobe
    assign short_kick = short_refresh_in ^ short_prev_q;
    assign long_kick  = long_refresh_in ^ long_prev_q;
    assign mr_act     = (mr_cnt_q == dws_pkg::MR_GLITCH_CYC);
    assign vout_act   = (vout_cnt_q == dws_pkg::VOUT_GLITCH_CYC);
    assign vcc_act    = (vcc_cnt_q == dws_pkg::VCC_DELAY_CYC);

    // Edge history for the refresh pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_prev_q <= 1'b0;
            long_prev_q  <= 1'b0;
        end else begin
            short_prev_q <= short_refresh_in;
            long_prev_q  <= long_refresh_in;
        end
    end

    // Persistence filters; a short low pulse restarts from zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mr_cnt_q   <= 40'h0000000000;
            vout_cnt_q <= 40'h0000000000;
            vcc_cnt_q  <= 40'h0000000000;
        end else begin
            mr_cnt_q   <= sat_inc(mr_cnt_q, dws_pkg::MR_GLITCH_CYC, !manual_reset_n_in);
            vout_cnt_q <= sat_inc(vout_cnt_q, dws_pkg::VOUT_GLITCH_CYC, vout_low_in);
            vcc_cnt_q  <= sat_inc(vcc_cnt_q, dws_pkg::VCC_DELAY_CYC, vcc_low_in);
        end
    end

    // ==========================================================
    // Short watchdog
    // Floating refresh disables it unless the lock input is high
    assign short_en  = wd_lock_select | !short_refresh_hiz_in;
    assign short_exp = short_en && !rst_q && last(short_cnt_q, SHORT_WD_CYC);

    // Counter held at zero during reset so it restarts afterwards
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_cnt_q <= 40'h0000000000;
        end else if (!short_en || short_kick || rst_q || short_exp) begin
            short_cnt_q <= 40'h0000000000;
        end else begin
            short_cnt_q <= short_cnt_q + 40'h0000000001;
        end
    end

    // ==========================================================
    // Long watchdog
    // Keeps running through short resets, so a host stuck in
    // a reset loop still gets power cycled
    assign long_exp = LONG_WD_EN && (state_q == dws_pkg::DWS_RUN)
                      && last(long_cnt_q, LONG_WD_CYC);

    // Long counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            long_cnt_q <= 40'h0000000000;
        end else if (!LONG_WD_EN || long_kick || long_exp
                     || state_q != dws_pkg::DWS_RUN) begin
            long_cnt_q <= 40'h0000000000;
        end else begin
            long_cnt_q <= long_cnt_q + 40'h0000000001;
        end
    end

    // ==========================================================
    // Power cycle sequencer
    always_comb begin
        case (state_q)
            dws_pkg::DWS_OFF:  pc_lim = POFF_CYC;
            dws_pkg::DWS_SEQ1: pc_lim = SEQ_CYC;
            dws_pkg::DWS_SEQ2: pc_lim = SEQ_CYC;
            dws_pkg::DWS_HOLD: pc_lim = CYC_HOLD_CYC;
            default:           pc_lim = 40'h0000000001;
        endcase
    end

    // Off, buck up, ldo up, then hold reset before release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= dws_pkg::DWS_RUN;
            pc_cnt_q <= 40'h0000000000;
        end else if (state_q == dws_pkg::DWS_RUN) begin
            pc_cnt_q <= 40'h0000000000;
            if (long_exp) begin
                state_q <= dws_pkg::DWS_OFF;
            end
        end else if (last(pc_cnt_q, pc_lim)) begin
            pc_cnt_q <= 40'h0000000000;
            case (state_q)
                dws_pkg::DWS_OFF:  state_q <= dws_pkg::DWS_SEQ1;
                dws_pkg::DWS_SEQ1: state_q <= dws_pkg::DWS_SEQ2;
                dws_pkg::DWS_SEQ2: state_q <= dws_pkg::DWS_HOLD;
                default:           state_q <= dws_pkg::DWS_RUN;
            endcase
        end else begin
            pc_cnt_q <= pc_cnt_q + 40'h0000000001;
        end
    end

    // ==========================================================
    // Reset generation
    // Power-on starts with a full hold; any active source except the long timeout reloads it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= RST_HOLD_CYC;
        end else if (mr_act || vout_act || vcc_act || short_exp || sw_req_q) begin
            hold_q <= RST_HOLD_CYC;
        end else if (hold_q != 40'h0000000000) begin
            hold_q <= hold_q - 40'h0000000001;
        end
    end

    // Open-drain cpu reset: drive low while any cause is present
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_q <= 1'b1;
        end else begin
            rst_q <= mr_act || vout_act || vcc_act || short_exp || sw_req_q
                     || hold_q != 40'h0000000000
                     || state_q != dws_pkg::DWS_RUN || long_exp;
        end
    end

    // ==========================================================
    // Timeout status
    // Low only after a long timeout, released by its own timer or by a short timeout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_low_q <= 1'b0;
            stat_cnt_q <= 40'h0000000000;
        end else if (long_exp) begin
            stat_low_q <= 1'b1;
            stat_cnt_q <= 40'h0000000000;
        end else if (short_exp) begin
            stat_low_q <= 1'b0;
            stat_cnt_q <= 40'h0000000000;
        end else if (stat_low_q) begin
            if (last(stat_cnt_q, STATUS_CLR_CYC)) begin
                stat_low_q <= 1'b0;
                stat_cnt_q <= 40'h0000000000;
            end else begin
                stat_cnt_q <= stat_cnt_q + 40'h0000000001;
            end
        end
    end

    // ==========================================================
    // Regulator control
    // Power cycle gates each enable; off state kills both
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buck_q <= 1'b0;
            ldo_q  <= 1'b0;
            fpwm_q <= 1'b0;
        end else begin
            buck_q <= buck_enable_in && state_q != dws_pkg::DWS_OFF && !long_exp;
            ldo_q  <= ldo_enable_in && state_q != dws_pkg::DWS_OFF
                      && state_q != dws_pkg::DWS_SEQ1 && !long_exp;
            fpwm_q <= buck_mode_in;
        end
    end

    // ==========================================================
    // APB slave
    // One wait-free access phase; pready is high on its first cycle
    assign access    = psel && penable && pready_q;
    assign wr_ctrl   = access && pwrite && paddr == dws_pkg::ADDR_CTRL;
    assign wr_cause  = access && pwrite && paddr == dws_pkg::ADDR_CAUSE;
    assign cause_set = '{sw: sw_req_q, supply: vout_act | vcc_act, manual: mr_act,
                         long_to: long_exp, short_to: short_exp};

    // Software reset request, a one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_req_q <= 1'b0;
        end else begin
            sw_req_q <= wr_ctrl && pwdata[dws_pkg::CTRL_SWRST];
        end
    end

    // Sticky causes, write one to clear; a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_q <= dws_pkg::CAUSE_RESET;
        end else if (wr_cause) begin
            cause_q <= (cause_q & ~pwdata[4:0]) | cause_set;
        end else begin
            cause_q <= cause_q | cause_set;
        end
    end

    // Read data and answer captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
            if (psel && !penable) begin
                if (paddr == dws_pkg::ADDR_CTRL) begin
                    prdata_q <= 32'h00000000;
                end else if (paddr == dws_pkg::ADDR_STATUS) begin
                    prdata_q <= {25'h0000000, state_q, ldo_q, buck_q, stat_low_q, rst_q};
                end else if (paddr == dws_pkg::ADDR_CAUSE) begin
                    prdata_q <= {27'h0000000, cause_q};
                end else begin
                    pslverr_q <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Outputs
    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign cpu_reset_n_out    = 1'b0;
    assign cpu_reset_n_oe     = rst_q;
    assign timeout_status_out = 1'b0;
    assign timeout_status_oe  = stat_low_q;
    assign buck_on_out        = buck_q;
    assign ldo_on_out         = ldo_q;
    assign buck_fpwm_out      = fpwm_q;

endmodule
`default_nettype wire

// [dv/dws_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dws_host_model #(
    parameter int PERIOD = 100
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic short_en,
    input  wire logic long_en,
    output logic      short_refresh_in,
    output logic      long_refresh_in
);
    logic [7:0] cnt_q;
    // ==========================================================
    // Strobe period, inside both timeouts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : 8'(cnt_q + 8'h01);
        end
    end
    // Each toggle is one strobe; disabled means no toggles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {short_refresh_in, long_refresh_in} <= 2'b00;
        end else if (cnt_q == 8'h00) begin
            if (short_en) short_refresh_in <= ~short_refresh_in;
            if (long_en) long_refresh_in <= ~long_refresh_in;
        end
    end
endmodule
`default_nettype wire

// [dv/dws_supervisor_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module dws_supervisor_asserts #(
    parameter logic [39:0] RST_HOLD_CYC   = dws_pkg::RST_HOLD_A_CYC,
    parameter logic [39:0] POFF_CYC       = dws_pkg::POFF_A_CYC,
    parameter logic [39:0] STATUS_CLR_CYC = dws_pkg::STATUS_CLR_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic manual_reset_n_in,
    input wire logic vout_low_in,
    input wire logic vcc_low_in,
    input wire logic buck_enable_in,
    input wire logic ldo_enable_in,
    input wire logic buck_mode_in,
    input wire logic cpu_reset_n_oe,
    input wire logic timeout_status_oe,
    input wire logic buck_on_out,
    input wire logic ldo_on_out,
    input wire logic buck_fpwm_out
);
    localparam int P_OFF = int'(POFF_CYC) - 1;
    logic [15:0] hold_q, st_q, vout_q, vcc_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Run lengths; 16 bits is enough here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {hold_q, st_q, vout_q, vcc_q} <= '0;
        end else begin
            hold_q <= cpu_reset_n_oe ? 16'(hold_q + 16'h0001) : 16'h0000;
            st_q   <= timeout_status_oe ? 16'(st_q + 16'h0001) : 16'h0000;
            vout_q <= vout_low_in ? 16'(vout_q + 16'h0001) : 16'h0000;
            vcc_q  <= vcc_low_in ? 16'(vcc_q + 16'h0001) : 16'h0000;
        end
    end
    // ==========================================================
    // Properties
    a_regs_follow_en: assert property ($past(presetn) && !timeout_status_oe |->
        buck_on_out == $past(buck_enable_in) && ldo_on_out == $past(ldo_enable_in))
        else $error("regulator off its enable");
    a_mode_follows: assert property ($past(presetn) |-> buck_fpwm_out == $past(buck_mode_in))
        else $error("mode output wrong");
    a_manual_reset: assert property (!manual_reset_n_in [*8] |=> cpu_reset_n_oe)
        else $error("manual reset ignored");
    a_hold_min: assert property ($fell(cpu_reset_n_oe) |-> hold_q >= 16'(RST_HOLD_CYC))
        else $error("reset released too early");
    a_status_clear: assert property (st_q <= 16'(STATUS_CLR_CYC) + 16'h0002)
        else $error("status not cleared");
    a_long_cycle: assert property ($rose(timeout_status_oe) |->
        cpu_reset_n_oe && !buck_on_out && !ldo_on_out) else $error("long event action wrong");
    a_off_period: assert property ($rose(timeout_status_oe) |->
        ##P_OFF (!buck_on_out && !ldo_on_out)) else $error("off period too short");
    a_seq_delay: assert property ($rose(buck_on_out) && timeout_status_oe |->
        !ldo_on_out [*8] ##[1:4] ldo_on_out) else $error("sequencing delay wrong");
    a_vout_filter: assert property (vout_q == 16'h0C80 |-> cpu_reset_n_oe)
        else $error("dip ignored");
    a_vcc_delay: assert property (vcc_q == 16'h0ED8 |-> cpu_reset_n_oe)
        else $error("supply fall ignored");
    c_long: cover property ($rose(timeout_status_oe));
    c_manual: cover property (!manual_reset_n_in && $rose(cpu_reset_n_oe));
    c_release: cover property ($fell(cpu_reset_n_oe));
endmodule
bind dws_supervisor dws_supervisor_asserts #(.RST_HOLD_CYC(RST_HOLD_CYC), .POFF_CYC(POFF_CYC),
    .STATUS_CLR_CYC(STATUS_CLR_CYC)) u_chk (.pclk(pclk), .presetn(presetn),
    .manual_reset_n_in(manual_reset_n_in), .vout_low_in(vout_low_in), .vcc_low_in(vcc_low_in),
    .buck_enable_in(buck_enable_in), .ldo_enable_in(ldo_enable_in), .buck_mode_in(buck_mode_in),
    .cpu_reset_n_oe(cpu_reset_n_oe), .timeout_status_oe(timeout_status_oe),
    .buck_on_out(buck_on_out), .ldo_on_out(ldo_on_out), .buck_fpwm_out(buck_fpwm_out));
`default_nettype wire

// [dv/tb_dual_watchdog_supervisor.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_dual_watchdog_supervisor;
    logic        pclk = 1'b0, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prng;
    logic        hiz, lock, mr_n, vout_low, vcc_low, buck_en, ldo_en, mode, s_en, l_en;
    logic [32:0] note, notes[$];
    wire logic [31:0] prdata;
    wire logic   pready, pslverr, s_ref, l_ref, rst_out, r_oe, w_out, w_oe, b_on, l_on, fpwm;
    int          n_fail = 0, checked = 0, cyc = 0, t0;
    // ==========================================================
    // Design and host
    dws_supervisor #(.SHORT_WD_CYC(40'hC8), .LONG_WD_CYC(40'h7D0),
        .RST_HOLD_CYC(40'h32), .CYC_HOLD_CYC(40'h14), .POFF_CYC(40'h28), .SEQ_CYC(40'hA),
        .STATUS_CLR_CYC(40'h12C)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .short_refresh_in(s_ref), .short_refresh_hiz_in(hiz),
        .long_refresh_in(l_ref), .wd_lock_select(lock), .manual_reset_n_in(mr_n),
        .vout_low_in(vout_low), .vcc_low_in(vcc_low), .buck_enable_in(buck_en),
        .ldo_enable_in(ldo_en), .buck_mode_in(mode), .cpu_reset_n_out(rst_out),
        .cpu_reset_n_oe(r_oe), .timeout_status_out(w_out), .timeout_status_oe(w_oe),
        .buck_on_out(b_on), .ldo_on_out(l_on), .buck_fpwm_out(fpwm));
    dws_host_model u_host (.pclk(pclk), .presetn(presetn), .short_en(s_en),
        .long_en(l_en), .short_refresh_in(s_ref), .long_refresh_in(l_ref));
    // ==========================================================
    // Clock, hang limit and verdict
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic conclude();
        if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // ==========================================================
    // Bus tasks; request held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
        notes.push_back({err, e});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic st(input logic [31:0] e);
        rd(dws_pkg::ADDR_STATUS, e, 1'b0);
    endtask
    task automatic wait_to(input int t);
        while (cyc < t) @(posedge pclk);
    endtask
    // Oldest note against each answer
    always @(posedge pclk) begin
        if (pready === 1'b1 && pwrite === 1'b0) begin
            note = notes.pop_front();
            `CHK({pslverr, prdata}, note)
            `CHK({rst_out, w_out}, 2'b00)
            if (paddr === dws_pkg::ADDR_STATUS)
                `CHK({l_on, b_on, w_oe, r_oe, fpwm}, {note[3:0], mode})
        end
    end
    // ==========================================================
    // Scenarios
    initial begin
        {psel, penable, pwrite, paddr, pwdata, hiz, lock, vout_low, vcc_low, mode} = '0;
        {mr_n, buck_en, ldo_en, s_en, l_en} = '1;
        presetn = 1'b0;
        prng = 32'h76410A5C;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        st(32'h0000000D);
        rd(8'h0C, 32'h0, 1'b1);
        apb(1'b1, dws_pkg::ADDR_STATUS, 32'hFF);
        repeat (60) @(posedge pclk);
        st(32'h0000000C);
        for (int i = 0; i < 8; i++) begin
            prng = lfsr(prng);
            {buck_en, ldo_en, mode} <= prng[2:0];
            st({28'h0, prng[1], prng[2], 2'b00});
        end
        {buck_en, ldo_en} <= 2'b11;
        // Short expiry leaves regulators on
        @(s_ref);
        t0 = cyc;
        s_en <= 1'b0;
        wait_to(t0 + 150);
        st(32'h0000000C);
        wait_to(t0 + 215);
        st(32'h0000000D);
        s_en <= 1'b1;
        wait_to(t0 + 300);
        st(32'h0000000C);
        // Manual reset: glitch, then a real press
        mr_n <= 1'b0;
        repeat (4) @(posedge pclk);
        mr_n <= 1'b1;
        st(32'h0000000C);
        mr_n <= 1'b0;
        repeat (20) @(posedge pclk);
        st(32'h0000000D);
        mr_n <= 1'b1;
        st(32'h0000000D);
        repeat (60) @(posedge pclk);
        st(32'h0000000C);
        rd(dws_pkg::ADDR_CAUSE, 32'h5, 1'b0);
        apb(1'b1, dws_pkg::ADDR_CAUSE, 32'h1F);
        rd(dws_pkg::ADDR_CAUSE, 32'h0, 1'b0);
        // Floating refresh disables unless locked
        {s_en, hiz} <= 2'b01;
        repeat (300) @(posedge pclk);
        st(32'h0000000C);
        lock <= 1'b1;
        t0 = cyc;
        wait_to(t0 + 212);
        st(32'h0000000D);
        {hiz, lock, s_en} <= 3'b001;
        repeat (70) @(posedge pclk);
        apb(1'b1, dws_pkg::ADDR_CTRL, 32'h1);
        st(32'h0000000D);
        repeat (60) @(posedge pclk);
        st(32'h0000000C);
        // Output dip, then supply fall; only a long one acts
        for (int k = 0; k < 2; k++) begin
            {vcc_low, vout_low} <= 2'(k + 1);
            repeat (3000 + 600 * k) @(posedge pclk);
            st(32'h0000000C);
            repeat (250) @(posedge pclk);
            st(32'h0000000D);
            {vcc_low, vout_low} <= 2'b00;
            repeat (60) @(posedge pclk);
            st(32'h0000000C);
        end
        // Long watchdog power cycle, state by state
        @(l_ref);
        t0 = cyc;
        l_en <= 1'b0;
        wait_to(t0 + 2015);
        st(32'h00000013);
        wait_to(t0 + 2046);
        st(32'h00000037);
        wait_to(t0 + 2056);
        st(32'h0000002F);
        wait_to(t0 + 2070);
        st(32'h0000006F);
        wait_to(t0 + 2095);
        st(32'h0000000E);
        l_en <= 1'b1;
        wait_to(t0 + 2330);
        st(32'h0000000C);
        repeat (2) @(posedge pclk);
        `CHK(notes.size(), 0)
        conclude();
    end
endmodule
`default_nettype wire

// [pkg/dws_pkg.sv]
// How it works
// - Short watchdog expiry: reset only, regulators stay
// - Long watchdog expiry: reset and power cycle
// - Short timeout option: 102 ms or 1.6 s
// - Long timeout options, or long watchdog disabled
// - Supervisor/short reset hold: 30 or 200 ms
// - Long event reset hold nominally 5 ms
// - Power cycle off time 210 or 400 ms
// - 2 ms between regulator turn-on events
// - Timeout status self-clears after 11.2 s
// - Manual reset low glitches up to 220 ns ignored
// - Manual reset drives cpu reset within 280 ns
// - Output-voltage dip must persist 125 us
// - Supply fall asserts reset after 150 us
// - Each regulator follows its own enable
// - Mode high forces PWM, low auto
// - Status high after short/POR, low after long
// - Floating short refresh, lock low: short disabled
// - Lock high keeps short watchdog active
// - Cpu reset is open-drain, active low
package dws_pkg;

    // ==========================================================
    // Clock and timing
    localparam real CLK_PERIOD_NS   = 40.0;
    localparam real SHORT_WD_A_MS   = 102.0;
    localparam real SHORT_WD_B_S    = 1.6;
    localparam real LONG_WD_A_S     = 7.5;
    localparam real LONG_WD_C_MIN   = 4.0;
    localparam real LONG_WD_D_MIN   = 8.0;
    localparam real LONG_WD_E_MIN   = 16.0;
    localparam real LONG_WD_F_MIN   = 32.0;
    localparam real LONG_WD_G_MIN   = 64.0;
    localparam real LONG_WD_H_MIN   = 128.0;
    localparam real RST_HOLD_A_MS   = 30.0;
    localparam real RST_HOLD_B_MS   = 200.0;
    localparam real CYC_HOLD_MS     = 5.0;
    localparam real POFF_A_MS       = 210.0;
    localparam real POFF_B_MS       = 400.0;
    localparam real SEQ_DELAY_MS    = 2.0;
    localparam real STATUS_CLR_S    = 11.2;
    localparam real MR_GLITCH_NS    = 220.0;
    localparam real VOUT_GLITCH_US  = 125.0;
    localparam real VCC_DELAY_US    = 150.0;

    localparam logic [39:0] SHORT_WD_A_CYC = 40'(SHORT_WD_A_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam logic [39:0] SHORT_WD_B_CYC = 40'(SHORT_WD_B_S * 1.0e9 / CLK_PERIOD_NS);
    localparam logic [39:0] LONG_WD_A_CYC  = 40'(LONG_WD_A_S * 1.0e9 / CLK_PERIOD_NS);
    localparam logic [39:0] LONG_WD_C_CYC  = 40'(LONG_WD_C_MIN * 6.0e10 / CLK_PERIOD_NS);
    localparam logic [39:0] LONG_WD_D_CYC  = 40'(LONG_WD_D_MIN * 6.0e10 / CLK_PERIOD_NS);
    localparam logic [39:0] LONG_WD_E_CYC  = 40'(LONG_WD_E_MIN * 6.0e10 / CLK_PERIOD_NS);
    localparam logic [39:0] LONG_WD_F_CYC  = 40'(LONG_WD_F_MIN * 6.0e10 / CLK_PERIOD_NS);
    localparam logic [39:0] LONG_WD_G_CYC  = 40'(LONG_WD_G_MIN * 6.0e10 / CLK_PERIOD_NS);
    localparam logic [39:0] LONG_WD_H_CYC  = 40'(LONG_WD_H_MIN * 6.0e10 / CLK_PERIOD_NS);
    localparam logic [39:0] RST_HOLD_A_CYC = 40'(RST_HOLD_A_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam logic [39:0] RST_HOLD_B_CYC = 40'(RST_HOLD_B_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam logic [39:0] CYC_HOLD_CYC   = 40'(CYC_HOLD_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam logic [39:0] POFF_A_CYC     = 40'(POFF_A_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam logic [39:0] POFF_B_CYC     = 40'(POFF_B_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam logic [39:0] SEQ_DELAY_CYC  = 40'(SEQ_DELAY_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam logic [39:0] STATUS_CLR_CYC = 40'(STATUS_CLR_S * 1.0e9 / CLK_PERIOD_NS);
    localparam logic [39:0] MR_GLITCH_CYC  = 40'(MR_GLITCH_NS / CLK_PERIOD_NS);
    localparam logic [39:0] VOUT_GLITCH_CYC = 40'(VOUT_GLITCH_US * 1.0e3 / CLK_PERIOD_NS);
    localparam logic [39:0] VCC_DELAY_CYC  = 40'(VCC_DELAY_US * 1.0e3 / CLK_PERIOD_NS);

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CAUSE  = 8'h08;
    localparam int         CTRL_SWRST  = 0;
    localparam logic [4:0] CAUSE_RESET = 5'h00;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        DWS_RUN  = 3'h0,
        DWS_OFF  = 3'h1,
        DWS_SEQ1 = 3'h3,
        DWS_SEQ2 = 3'h2,
        DWS_HOLD = 3'h6
    } dws_pc_state_t;

    typedef struct packed {
        logic sw;
        logic supply;
        logic manual;
        logic long_to;
        logic short_to;
    } dws_cause_t;

endpackage
